// File: logic/ftm_pkg.sv
// Constants and shared duration arithmetic for the flash timer block
package ftm_pkg;
	// ========================================
	// Register map
	localparam logic [7:0] FTM_ADDR_DURATION = 8'h1B;
	localparam logic [7:0] FTM_ADDR_INHIBIT = 8'h1C;
	localparam logic [7:0] FTM_ADDR_CONTROL = 8'h1D;
	localparam logic [7:0] FTM_ADDR_STATUS = 8'h1E;
	// ========================================
	// Reset values and field layout
	localparam logic [5:0] FTM_DURATION_RESET = 6'h24;
	localparam logic [3:0] FTM_INHIBIT_RESET = 4'h0;
	localparam logic FTM_HALVING_RESET = 1'b0;
	localparam int FTM_MODE_BIT = 0;
	localparam int FTM_CODE_LSB = 1;
	localparam int FTM_CODE_MSB = 5;
	localparam int FTM_INH_MSB = 3;
	localparam int FTM_HALVING_BIT = 0;
	localparam int FTM_STAT_RUN_BIT = 0;
	localparam int FTM_STAT_TRIG_BIT = 1;
	localparam int FTM_STAT_SUPP_BIT = 2;
	// ========================================
	// Duration in internal clock periods
	localparam int FTM_CODE_W = 5;
	localparam int FTM_COUNT_W = 22;
	localparam logic [4:0] FTM_CODE_SAT = 5'h12;
	localparam logic [21:0] FTM_BASE_PERIODS = 22'h0493E0;
	localparam logic [21:0] FTM_STEP_PERIODS = 22'h0249F0;

	typedef logic [FTM_COUNT_W-1:0] ftm_count_type;

	// Codes above the default saturate at the default length
	function automatic ftm_count_type ftm_limit(input logic [FTM_CODE_W-1:0] code);
		logic [FTM_CODE_W-1:0] c;
		logic [43:0] prod;
		c = (code > FTM_CODE_SAT) ? FTM_CODE_SAT : code;
		prod = {17'h0, FTM_STEP_PERIODS} * {39'h0, c};
		return FTM_BASE_PERIODS + prod[FTM_COUNT_W-1:0];
	endfunction
endpackage

// File: logic/ftm_timer_if.sv
// Interface between the flash control and the duration counter
`timescale 1ns/1ps
interface ftm_timer_if;
	logic start;
	logic stop;
	logic tick;
	logic [ftm_pkg::FTM_CODE_W-1:0] code;
	logic running;
	logic expired;

	modport ctrl (output start, output stop, output tick, output code,
		input running, input expired);
	modport timer (input start, input stop, input tick, input code,
		output running, output expired);
endinterface

// File: logic/ftm_timer.sv
// Flash duration counter in internal clock periods
`timescale 1ns/1ps
module ftm_timer (
	input wire logic sys_clk,
	input wire logic rst,
	ftm_timer_if.timer tif
);
	typedef struct packed {
		logic running;
		logic expired;
		ftm_pkg::ftm_count_type count;
		ftm_pkg::ftm_count_type limit;
	} ftm_timer_state_type;

	ftm_timer_state_type s;
	ftm_timer_state_type next_s;

	// ========================================
	// Counter
	always_comb begin
		next_s = s;
		next_s.expired = 1'b0;
		if (tif.start) begin
			// Code is latched here so a write mid-flash cannot cut it short
			next_s.running = 1'b1;
			next_s.count = '0;
			next_s.limit = ftm_pkg::ftm_limit(tif.code);
		end else if (tif.stop) begin
			next_s.running = 1'b0;
		end else if (s.running && tif.tick) begin
			if (s.count == s.limit - 22'h000001) begin
				next_s.running = 1'b0;
				next_s.expired = 1'b1;
			end else begin
				next_s.count = s.count + 22'h000001;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tif.running = s.running;
	assign tif.expired = s.expired;

	// ========================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	limit_from_code_a: assert property (tif.start |=> s.limit == (($past(tif.code) >= 5'h12) ?
		22'd3000000 : 22'd300000 + 22'd150000 * $past(tif.code)))
		else $error("latched limit wrong");
	expiry_at_limit_a: assert property (tif.expired |->
		$past(s.count) == s.limit - 22'd1 && !s.running)
		else $error("expiry at wrong count");
endmodule

// File: logic/ftm_flash_ctrl.sv
// Flash timer, end selection, inhibit level and register port
//
// How it works
// - Flash lasts 300000 internal periods at code zero, plus 150000 per step.
// - On-time code resets to 10010, giving 3000000 periods; 10001 gives 2850000.
// - Codes 10011 through 11111 saturate at the 3000000-period default.
// - Duration register: code in bits 5:1, end select in bit 0, 7:6 read zero.
// - End select 0: only trigger low ends flash; 1: trigger low or timeout.
// - Inhibit level in bits 3:0, off at reset, 50 mA steps; upper bits zero.
// - Internal clock is the master clock pin or that clock halved.
// - Read-only running flag is 1 while the timer counts, else 0.
`timescale 1ns/1ps
module ftm_flash_ctrl (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic master_clock_pin,
	input wire logic flash_trigger_pin,
	input wire logic flash_suppress_pin,
	output logic flash_on,
	output logic inhibit_on,
	output logic [3:0] inhibit_drive_code,
	output logic flash_timer_running
);
	typedef struct packed {
		logic [1:0] trig_sync;
		logic [1:0] supp_sync;
		logic [1:0] mclk_sync;
		logic trig_prev;
		logic mclk_prev;
		logic half;
		logic [ftm_pkg::FTM_CODE_W-1:0] code;
		logic mode;
		logic [3:0] inh;
		logic halving;
		logic flash;
		logic inhibit;
		logic [7:0] rdata;
	} ftm_ctrl_state_type;

	ftm_ctrl_state_type s;
	ftm_ctrl_state_type next_s;
	ftm_timer_if tif ();

	logic trig_rise;
	logic trig_fall;
	logic mclk_rise;
	logic tick;

	ftm_timer u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.tif(tif.timer)
	);

	// ========================================
	// Edges of the synchronised pins
	// Only the second stage is looked at; the first may be metastable
	assign trig_rise = s.trig_sync[1] & ~s.trig_prev;
	assign trig_fall = ~s.trig_sync[1] & s.trig_prev;
	assign mclk_rise = s.mclk_sync[1] & ~s.mclk_prev;
	// Master clock must be well below half of sys_clk or edges are lost
	assign tick = mclk_rise & (~s.halving | s.half);

	assign tif.start = trig_rise;
	assign tif.stop = trig_fall;
	assign tif.tick = tick;
	assign tif.code = s.code;

	// ========================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.trig_sync = {s.trig_sync[0], flash_trigger_pin};
		next_s.supp_sync = {s.supp_sync[0], flash_suppress_pin};
		next_s.mclk_sync = {s.mclk_sync[0], master_clock_pin};
		next_s.trig_prev = s.trig_sync[1];
		next_s.mclk_prev = s.mclk_sync[1];
		if (mclk_rise) begin
			next_s.half = ~s.half;
		end
		if (!s.halving) begin
			next_s.half = 1'b0;
		end
		// Flash lifetime
		if (trig_rise) begin
			next_s.flash = 1'b1;
		end else if (trig_fall) begin
			next_s.flash = 1'b0;
		end else if (tif.expired && s.mode) begin
			next_s.flash = 1'b0;
		end
		next_s.inhibit = next_s.flash & s.supp_sync[1];
		// Register writes; reserved bits are dropped
		if (wr) begin
			unique case (addr)
				ftm_pkg::FTM_ADDR_DURATION: begin
					next_s.code = wdata[ftm_pkg::FTM_CODE_MSB:ftm_pkg::FTM_CODE_LSB];
					next_s.mode = wdata[ftm_pkg::FTM_MODE_BIT];
				end
				ftm_pkg::FTM_ADDR_INHIBIT: begin
					next_s.inh = wdata[ftm_pkg::FTM_INH_MSB:0];
				end
				ftm_pkg::FTM_ADDR_CONTROL: begin
					next_s.halving = wdata[ftm_pkg::FTM_HALVING_BIT];
				end
				default: begin
				end
			endcase
		end
		// Register reads, answered in the following cycle
		next_s.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				ftm_pkg::FTM_ADDR_DURATION: begin
					next_s.rdata = {2'b00, s.code, s.mode};
				end
				ftm_pkg::FTM_ADDR_INHIBIT: begin
					next_s.rdata = {4'h0, s.inh};
				end
				ftm_pkg::FTM_ADDR_CONTROL: begin
					next_s.rdata = {7'h00, s.halving};
				end
				ftm_pkg::FTM_ADDR_STATUS: begin
					next_s.rdata = {5'h00, s.supp_sync[1], s.trig_sync[1], tif.running};
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	// ========================================
	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			s.code <= ftm_pkg::FTM_DURATION_RESET[ftm_pkg::FTM_CODE_MSB:ftm_pkg::FTM_CODE_LSB];
			s.mode <= ftm_pkg::FTM_DURATION_RESET[ftm_pkg::FTM_MODE_BIT];
			s.inh <= ftm_pkg::FTM_INHIBIT_RESET;
			s.halving <= ftm_pkg::FTM_HALVING_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ========================================
	// Outputs
	assign rdata = s.rdata;
	assign flash_on = s.flash;
	assign inhibit_on = s.inhibit;
	assign inhibit_drive_code = s.inh;
	assign flash_timer_running = tif.running;

	// ========================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	reset_code_a: assert property ($past(rst) |->
		s.code == 5'h12 && !s.mode && s.inh == 4'h0)
		else $error("reset values wrong");
	duration_read_a: assert property (rd && addr == ftm_pkg::FTM_ADDR_DURATION |=>
		rdata[7:6] == 2'b00 && rdata[5:1] == $past(s.code) && rdata[0] == $past(s.mode))
		else $error("duration read wrong");
	inhibit_read_a: assert property (rd && addr == ftm_pkg::FTM_ADDR_INHIBIT |=>
		rdata[7:4] == 4'h0 && rdata[3:0] == $past(s.inh))
		else $error("inhibit read wrong");
	status_read_a: assert property (rd && addr == ftm_pkg::FTM_ADDR_STATUS |=>
		rdata[7:3] == 5'h00 && rdata[0] == $past(flash_timer_running))
		else $error("running flag read wrong");
	mode_zero_hold_a: assert property (tif.expired && !s.mode && !trig_fall && flash_on
		|=> flash_on)
		else $error("timeout ended flash in trigger mode");
	// A retrigger in the expiry cycle restarts the flash, so it is left out here
	mode_one_end_a: assert property (tif.expired && s.mode && !trig_rise |=> !flash_on)
		else $error("timeout did not end flash");
	trigger_start_a: assert property (trig_rise |=> flash_timer_running && flash_on)
		else $error("timer did not start");
	trigger_stop_a: assert property (trig_fall |=> !flash_timer_running && !flash_on)
		else $error("timer did not stop");
	running_in_flash_a: assert property (flash_timer_running |-> flash_on)
		else $error("timer runs outside flash");
	halved_tick_a: assert property (s.halving && tick |=> (!tick) [*2])
		else $error("halved clock ticks too often");
	direct_tick_a: assert property (!s.halving && mclk_rise |-> tick)
		else $error("direct clock tick lost");
endmodule

// File: sim/ftm_pin_model.sv
// Model of the master clock source feeding the flash timer block
`timescale 1ns/1ps
module ftm_pin_model (
	input wire logic sys_clk,
	input wire logic rst,
	output logic master_clock_pin
);
	// ========================================
	// Free-running master clock at a quarter of sys_clk
	// Fast enough for short runs, slow enough that the sync sees every edge
	logic [1:0] div;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end
	assign master_clock_pin = div[1];
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the flash timer and inhibit level block
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic master_clock_pin;
	logic flash_trigger_pin = 1'b0;
	logic flash_suppress_pin = 1'b0;
	logic flash_on;
	logic inhibit_on;
	logic [3:0] inhibit_drive_code;
	logic flash_timer_running;
	logic rd_seen = 1'b0;
	logic [7:0] expect_q[$];
	logic [7:0] rv;
	int fails = 0;
	int compares = 0;
	int seed = 47;

	always #12.5 sys_clk = ~sys_clk;

	ftm_pin_model partner (.sys_clk(sys_clk), .rst(rst), .master_clock_pin(master_clock_pin));

	ftm_flash_ctrl uut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .master_clock_pin(master_clock_pin),
		.flash_trigger_pin(flash_trigger_pin), .flash_suppress_pin(flash_suppress_pin),
		.flash_on(flash_on), .inhibit_on(inhibit_on),
		.inhibit_drive_code(inhibit_drive_code), .flash_timer_running(flash_timer_running));

	// ========================================
	// Checking
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		rd_seen <= rd;
		if (rd_seen) begin
			chk(rdata, expect_q.pop_front());
		end
	end

	task automatic final_report();
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ========================================
	// Register bus, one idle cycle between strobes
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		expect_q.push_back(exp);
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Pins pass two sync flops, so the flash answers a few cycles late
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		while (flash_on !== v && n < 12) begin
			@(negedge sys_clk);
			n++;
		end
		chk({7'h0, flash_on}, {7'h0, v});
		@(posedge sys_clk);
	endtask

	task automatic run_flash(input logic [7:0] dur, input logic supp);
		reg_wr(ftm_pkg::FTM_ADDR_DURATION, dur);
		flash_suppress_pin <= supp;
		flash_trigger_pin <= 1'b1;
		wait_lvl(1'b1);
		chk({7'h0, flash_timer_running}, 8'h01);
		chk({7'h0, inhibit_on}, {7'h0, supp});
		reg_rd(ftm_pkg::FTM_ADDR_STATUS, {5'h00, supp, 2'h3});
		reg_wr(ftm_pkg::FTM_ADDR_DURATION, 8'h3E);
		flash_trigger_pin <= 1'b0;
		wait_lvl(1'b0);
		chk({7'h0, flash_timer_running}, 8'h00);
		reg_rd(ftm_pkg::FTM_ADDR_STATUS, {5'h00, supp, 2'h0});
	endtask

	// ========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		reg_rd(ftm_pkg::FTM_ADDR_DURATION, 8'h24);
		reg_rd(ftm_pkg::FTM_ADDR_INHIBIT, 8'h00);
		reg_rd(ftm_pkg::FTM_ADDR_CONTROL, 8'h00);
		reg_rd(8'h55, 8'h00);
		chk({4'h0, inhibit_drive_code}, 8'h00);
		chk({7'h0, flash_timer_running}, 8'h00);
		for (int i = 0; i < 6; i++) begin
			rv = 8'($random(seed));
			reg_wr(ftm_pkg::FTM_ADDR_DURATION, rv);
			reg_rd(ftm_pkg::FTM_ADDR_DURATION, rv & 8'h3F);
			reg_wr(ftm_pkg::FTM_ADDR_INHIBIT, rv);
			reg_rd(ftm_pkg::FTM_ADDR_INHIBIT, {4'h0, rv[3:0]});
			chk({4'h0, inhibit_drive_code}, {4'h0, rv[3:0]});
			reg_wr(ftm_pkg::FTM_ADDR_CONTROL, rv);
			reg_rd(ftm_pkg::FTM_ADDR_CONTROL, {7'h0, rv[0]});
			reg_wr(8'h55, rv);
			reg_rd(8'h55, 8'h00);
		end
		// Write then read with no gap between the strobes
		addr <= ftm_pkg::FTM_ADDR_DURATION;
		wdata <= 8'h5A;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		expect_q.push_back(8'h1A);
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
		reg_wr(ftm_pkg::FTM_ADDR_STATUS, 8'hFF);
		reg_rd(ftm_pkg::FTM_ADDR_STATUS, 8'h00);
		reg_wr(ftm_pkg::FTM_ADDR_CONTROL, 8'h00);
		run_flash(8'h01, 1'b1);
		run_flash(8'h24, 1'b0);
		reg_wr(ftm_pkg::FTM_ADDR_CONTROL, 8'h01);
		run_flash(8'h27, 1'b1);
		repeat (4) @(posedge sys_clk);
		final_report();
	end

	// Whole sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		final_report();
	end
endmodule
